// ### design/nfc_pkg.sv
// Constants, register map and types for the NVM status and fuse configuration block.
package nfc_pkg;

  // Wishbone geometry; a register index sits in address bits 6:2.
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 5;

  // Register indices; the byte address is four times the index.
  localparam logic [4:0] IDX_STATUS = 5'h04;
  localparam logic [4:0] IDX_LOCK = 5'h07;
  localparam logic [4:0] IDX_NVM_INTERRUPT_LEVEL_CONTROL = 5'h0D;
  localparam logic [4:0] IDX_FUSE1 = 5'h11;
  localparam logic [4:0] IDX_FUSE2 = 5'h12;
  localparam logic [4:0] IDX_FUSE4 = 5'h14;

  // Reset values.
  localparam logic [7:0] FUSE1_RST = 8'h00;
  localparam logic [7:0] FUSE2_RST = 8'hFF;
  localparam logic [7:0] FUSE4_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [3:0] NVM_INTERRUPT_LEVEL_CONTROL_RST = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Field positions.
  localparam int unsigned BIT_NVM_BUSY = 7;
  localparam int unsigned BIT_FLASH_BUSY = 6;
  localparam int unsigned BIT_EE_LOADED = 1;
  localparam int unsigned BIT_FLASH_LOADED = 0;
  localparam int unsigned INT_SPM_LSB = 2;
  localparam int unsigned INT_EE_LSB = 0;
  localparam int unsigned INT_W = 4;
  localparam int unsigned FUSE1_WIN_LSB = 4;
  localparam int unsigned FUSE1_TO_LSB = 0;
  localparam int unsigned FUSE2_BOOT = 6;
  localparam int unsigned FUSE2_OSC = 5;
  localparam int unsigned FUSE2_BOD_LSB = 0;
  localparam int unsigned FUSE4_RSTDIS = 4;
  localparam int unsigned FUSE4_START_LSB = 2;
  localparam int unsigned FUSE4_WDOG_CONFIG_LOCK = 1;

  // Interrupt level codes: 00 off, 01 low, 10 medium, 11 high.
  localparam logic [1:0] LVL_OFF = 2'h0;

  // Start-up delay codes and their counts of 1 kHz oscillator cycles.
  localparam logic [1:0] SU_64 = 2'h0;
  localparam logic [1:0] SU_4 = 2'h1;
  localparam logic [1:0] SU_RES = 2'h2;
  localparam logic [1:0] SU_0 = 2'h3;
  localparam logic [6:0] SU_CNT_64 = 7'h40;
  localparam logic [6:0] SU_CNT_4 = 7'h04;
  localparam logic [6:0] SU_CNT_0 = 7'h00;
  localparam logic [6:0] SU_CNT_ONE = 7'h01;

  // Application reset address.
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

  // Reset release sequencer states.
  typedef enum logic [1:0] {
    NFC_HOLD = 2'b00,
    NFC_DELAY = 2'b01,
    NFC_RUN = 2'b10
  } nfc_rst_e;

endpackage : nfc_pkg

// ### design/nfc_top.sv
// NVM status, ready interrupts, lock mirror and fuse configuration with a Wishbone slave.
//
// How it works
// RQ1 - Interrupt control bits 3:2 enable and set level of self-program ready interrupt.
// RQ2 - Interrupt control bits 1:0 enable and set level of EEPROM ready interrupt.
// RQ3 - Both ready interrupts are levels, requested only while enabled and not busy.
// RQ4 - Software enables a ready interrupt after starting a command, disables it in handler.
// RQ5 - Status bit 7 sets on any programming start and clears when it finishes.
// RQ6 - Status bit 6 marks flash programming and blocks application flash access meanwhile.
// RQ7 - Status bit 1 sets on EEPROM buffer load, clears on page write or flush.
// RQ8 - Status bit 0 sets on flash buffer load, clears on page write or flush.
// RQ9 - Lock bits appear as a read-only byte at index 0x07.
// RQ10 - Software writes zero into reserved bits of interrupt control and status.
// RQ11 - During reset fuse byte 1 bits 7:4 load the watchdog window period.
// RQ12 - During reset fuse byte 1 bits 3:0 load the watchdog timeout period.
// RQ13 - Boot vector fuse 0 starts at boot loader, 1 starts at address 0x0000.
// RQ14 - Fuse byte 2 bit 5 places the 32.768kHz oscillator: 0 alternate, 1 crystal pins.
// RQ15 - Fuse byte 2 bits 1:0 set brownout behaviour in sleep other than idle.
// RQ16 - Software writes ones into reserved bits of fuse bytes 2 and 4.
// RQ17 - Programmed external reset disable fuse makes a low reset pin ineffective.
// RQ18 - Fuse byte 4 bits 3:2 select start-up delay in 1 kHz oscillator cycles.
// RQ19 - Changed reset-disable and start-up fuses read back new values only after reset.
// RQ20 - Start-up codes: 00 gives 64, 01 gives 4, 10 reserved, 11 gives 0.
// RQ21 - Watchdog lock fuse 0 locks watchdog configuration, 1 leaves it unlocked.
// RQ22 - Level 00 disables an interrupt; other codes request low, medium, high.
`timescale 1ns/1ps

module nfc_top #(
  parameter logic [15:0] BOOT_ADDR = 16'h8000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [nfc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [nfc_pkg::DAT_W-1:0] wb_dat_i,
  output logic [nfc_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic op_start_i,
  input wire logic op_is_flash_i,
  input wire logic op_done_i,
  input wire logic ee_byte_load_i,
  input wire logic flash_byte_load_i,
  input wire logic ee_buf_clear_i,
  input wire logic flash_buf_clear_i,
  input wire logic [7:0] lock_bits_i,
  input wire logic ext_reset_n_i,
  input wire logic ulp_tick_i,
  output logic [1:0] spm_ready_int_o,
  output logic [1:0] ee_ready_int_o,
  output logic app_flash_block_o,
  output logic [3:0] wdog_window_period_o,
  output logic [3:0] wdog_timeout_o,
  output logic boot_from_loader_o,
  output logic [15:0] reset_vector_o,
  output logic osc_on_xtal_pins_o,
  output logic [1:0] brownout_sleep_mode_o,
  output logic wdog_config_lock_o,
  output logic internal_reset_o
);
  import nfc_pkg::*;

  logic ack_ff;
  logic [DAT_W-1:0] dat_ff;
  logic [7:0] rd_byte;
  logic [IDX_W-1:0] idx;
  logic wr_en;
  logic rd_take;
  logic nvm_busy_ff;
  logic flash_busy_ff;
  logic ee_loaded_ff;
  logic flash_loaded_ff;
  logic [INT_W-1:0] nvm_interrupt_level_control_ff;
  logic [7:0] lock_ff;
  logic [7:0] fuse1_ff;
  logic [7:0] fuse2_ff;
  logic [7:0] fuse4_ff;
  logic [7:0] fuse2_act_ff;
  logic [7:0] fuse4_act_ff;
  logic boot_ldr_ff;
  logic wdog_config_lock_ff;
  logic [1:0] spm_int_ff;
  logic [1:0] ee_int_ff;
  logic [3:0] wdog_win_ff;
  logic [3:0] wdog_to_ff;
  logic [15:0] rst_vec_ff;
  logic int_rst_ff;
  logic ext_rst_req;
  logic [6:0] su_cnt_ff;
  logic [6:0] su_target;
  nfc_rst_e state_ff;
  nfc_rst_e nxt_state;

  // Bus decode; a write lands at the edge where the master sees ack high.
  assign idx = wb_adr_i[IDX_LSB +: IDX_W];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
  assign rd_take = wb_cyc_i && wb_stb_i && !ack_ff;

  // Wishbone ack rises one cycle after the request and falls the next.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  // Read multiplexer; unmapped indices read as zero.
  always_comb begin
    rd_byte = BYTE_ZERO;
    unique case (idx)
      IDX_STATUS: begin
        rd_byte[BIT_NVM_BUSY] = nvm_busy_ff;
        rd_byte[BIT_FLASH_BUSY] = flash_busy_ff;
        rd_byte[BIT_EE_LOADED] = ee_loaded_ff;
        rd_byte[BIT_FLASH_LOADED] = flash_loaded_ff;
      end
      IDX_LOCK: rd_byte = lock_ff; // RQ9
      IDX_NVM_INTERRUPT_LEVEL_CONTROL: rd_byte[INT_W-1:0] = nvm_interrupt_level_control_ff;
      IDX_FUSE1: rd_byte = fuse1_ff;
      IDX_FUSE2: rd_byte = fuse2_ff;
      IDX_FUSE4: begin
        rd_byte = fuse4_ff;
        rd_byte[FUSE4_RSTDIS] = fuse4_act_ff[FUSE4_RSTDIS]; // RQ19
        rd_byte[FUSE4_START_LSB +: 2] = fuse4_act_ff[FUSE4_START_LSB +: 2]; // RQ19
        rd_byte[FUSE4_WDOG_CONFIG_LOCK] = fuse4_act_ff[FUSE4_WDOG_CONFIG_LOCK];
      end
      default: rd_byte = BYTE_ZERO;
    endcase
  end

  // Read data is captured as ack rises and holds while ack is high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= WORD_ZERO;
    end else if (rd_take) begin
      dat_ff <= {24'h000000, rd_byte};
    end
  end

  // Interrupt level control; only bits 3:0 are stored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_interrupt_level_control_ff <= NVM_INTERRUPT_LEVEL_CONTROL_RST;
    end else if (wr_en && idx == IDX_NVM_INTERRUPT_LEVEL_CONTROL) begin
      nvm_interrupt_level_control_ff <= wb_dat_i[INT_W-1:0]; // RQ1 RQ2
    end
  end

  // Fuse storage survives system reset and is loaded with its reset values only at power-on.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      fuse1_ff <= FUSE1_RST;
      fuse2_ff <= FUSE2_RST;
      fuse4_ff <= FUSE4_RST;
    end else if (wr_en) begin
      if (idx == IDX_FUSE1) begin
        fuse1_ff <= wb_dat_i[7:0];
      end
      if (idx == IDX_FUSE2) begin
        fuse2_ff <= wb_dat_i[7:0];
      end
      if (idx == IDX_FUSE4) begin
        fuse4_ff <= wb_dat_i[7:0];
      end
    end
  end

  // Busy flags; a start in the same cycle as a finish wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_busy_ff <= 1'b0;
      flash_busy_ff <= 1'b0;
    end else begin
      if (op_start_i) begin
        nvm_busy_ff <= 1'b1; // RQ5
      end else if (op_done_i) begin
        nvm_busy_ff <= 1'b0; // RQ5
      end
      if (op_start_i && op_is_flash_i) begin
        flash_busy_ff <= 1'b1; // RQ6
      end else if (op_done_i) begin
        flash_busy_ff <= 1'b0; // RQ6
      end
    end
  end

  // Page buffer loaded flags; a load beats a page write or flush.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ee_loaded_ff <= 1'b0;
      flash_loaded_ff <= 1'b0;
    end else begin
      if (ee_byte_load_i) begin
        ee_loaded_ff <= 1'b1; // RQ7
      end else if (ee_buf_clear_i) begin
        ee_loaded_ff <= 1'b0; // RQ7
      end
      if (flash_byte_load_i) begin
        flash_loaded_ff <= 1'b1; // RQ8
      end else if (flash_buf_clear_i) begin
        flash_loaded_ff <= 1'b0; // RQ8
      end
    end
  end

  // Lock bit mirror follows the nonvolatile lock bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_ff <= LOCK_RST;
    end else begin
      lock_ff <= lock_bits_i; // RQ9
    end
  end

  // Ready requests are levels gated by the busy flag; level 00 requests nothing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spm_int_ff <= LVL_OFF;
      ee_int_ff <= LVL_OFF;
    end else begin
      spm_int_ff <= nvm_busy_ff ? LVL_OFF : nvm_interrupt_level_control_ff[INT_SPM_LSB +: 2]; // RQ1 RQ3 RQ22
      ee_int_ff <= nvm_busy_ff ? LVL_OFF : nvm_interrupt_level_control_ff[INT_EE_LSB +: 2]; // RQ2 RQ3 RQ22
    end
  end

  // A low reset pin is a reset source unless the disable fuse is programmed.
  assign ext_rst_req = !ext_reset_n_i && fuse4_act_ff[FUSE4_RSTDIS]; // RQ17

  // Start-up delay target from the latched select; the reserved code acts as 64.
  always_comb begin
    unique case (fuse4_act_ff[FUSE4_START_LSB +: 2])
      SU_64: su_target = SU_CNT_64; // RQ20
      SU_4: su_target = SU_CNT_4; // RQ20
      SU_RES: su_target = SU_CNT_64;
      SU_0: su_target = SU_CNT_0; // RQ20
    endcase
  end

  // Reset release sequencer next state.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      NFC_HOLD: nxt_state = NFC_DELAY;
      NFC_DELAY: begin
        if (su_cnt_ff >= su_target) begin
          nxt_state = NFC_RUN; // RQ18
        end
      end
      NFC_RUN: nxt_state = NFC_RUN;
      default: nxt_state = NFC_HOLD;
    endcase
    if (ext_rst_req) begin
      nxt_state = NFC_HOLD; // RQ17
    end
  end

  // Sequencer state, delay counter and the internal reset output.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= NFC_HOLD;
      su_cnt_ff <= SU_CNT_0;
      int_rst_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      int_rst_ff <= (nxt_state != NFC_RUN);
      if (state_ff == NFC_DELAY && ulp_tick_i) begin
        su_cnt_ff <= su_cnt_ff + SU_CNT_ONE; // RQ18
      end else if (state_ff != NFC_DELAY) begin
        su_cnt_ff <= SU_CNT_0;
      end
    end
  end

  // Fuse settings are taken over while system reset is held or the sequencer is in NFC_HOLD.
  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff == NFC_HOLD) begin
      wdog_win_ff <= fuse1_ff[FUSE1_WIN_LSB +: 4]; // RQ11
      wdog_to_ff <= fuse1_ff[FUSE1_TO_LSB +: 4]; // RQ12
      fuse2_act_ff <= fuse2_ff;
      fuse4_act_ff <= fuse4_ff; // RQ19
      rst_vec_ff <= fuse2_ff[FUSE2_BOOT] ? APP_RESET_ADDR : BOOT_ADDR; // RQ13
      boot_ldr_ff <= !fuse2_ff[FUSE2_BOOT]; // RQ13
      wdog_config_lock_ff <= !fuse4_ff[FUSE4_WDOG_CONFIG_LOCK]; // RQ21
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign spm_ready_int_o = spm_int_ff;
  assign ee_ready_int_o = ee_int_ff;
  assign app_flash_block_o = flash_busy_ff; // RQ6
  assign wdog_window_period_o = wdog_win_ff;
  assign wdog_timeout_o = wdog_to_ff;
  assign boot_from_loader_o = boot_ldr_ff; // RQ13
  assign reset_vector_o = rst_vec_ff;
  assign osc_on_xtal_pins_o = fuse2_act_ff[FUSE2_OSC]; // RQ14
  assign brownout_sleep_mode_o = fuse2_act_ff[FUSE2_BOD_LSB +: 2]; // RQ15
  assign wdog_config_lock_o = wdog_config_lock_ff; // RQ21
  assign internal_reset_o = int_rst_ff;

  // Checks of the block's own behaviour.
  a_busy_on_start: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
    op_start_i |=> nvm_busy_ff)
    else $error("busy flag did not set on operation start");
  a_busy_on_done: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
    op_done_i && !op_start_i |=> !nvm_busy_ff && !flash_busy_ff)
    else $error("busy flags did not clear on operation done");
  a_flash_block: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
    op_start_i && op_is_flash_i |=> app_flash_block_o && flash_busy_ff)
    else $error("flash access not blocked during flash programming");
  a_ee_load_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
    ee_loaded_ff && !ee_buf_clear_i |=> ee_loaded_ff)
    else $error("EEPROM loaded flag dropped without clear");
  a_flash_load_set: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    flash_byte_load_i |=> flash_loaded_ff)
    else $error("flash loaded flag did not set on load");
  a_int_busy_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    nvm_busy_ff |=> spm_ready_int_o == LVL_OFF && ee_ready_int_o == LVL_OFF)
    else $error("ready interrupt requested while busy");
  a_int_level: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    !nvm_busy_ff |=> spm_ready_int_o == $past(nvm_interrupt_level_control_ff[INT_SPM_LSB +: 2]))
    else $error("ready interrupt level does not follow control field");
  a_lock_mirror: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
    !rst_i |=> lock_ff == $past(lock_bits_i))
    else $error("lock mirror does not follow lock bits");
  a_wdog_copy: assert property (@(posedge clk_i) // RQ12
    rst_i && !por_i |=> wdog_timeout_o == $past(fuse1_ff[FUSE1_TO_LSB +: 4]))
    else $error("watchdog period not loaded from fuse during reset");
  a_zero_delay: assert property (@(posedge clk_i) disable iff (rst_i || ext_rst_req) // RQ20
    state_ff == NFC_HOLD && fuse4_act_ff[FUSE4_START_LSB +: 2] == SU_0 |-> ##2 !internal_reset_o)
    else $error("zero start-up delay did not release reset");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // Checks of interrupt levels, buffer clear, fuse takeover and the reset sequencer.
  a_ee_level: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    !nvm_busy_ff |=> ee_ready_int_o == $past(nvm_interrupt_level_control_ff[INT_EE_LSB +: 2]))
    else $error("EEPROM ready level does not follow control field");
  a_buf_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    flash_buf_clear_i && !flash_byte_load_i |=> !flash_loaded_ff)
    else $error("flash loaded flag did not clear on page write or flush");
  a_window_copy: assert property (@(posedge clk_i) // RQ11
    rst_i && !por_i |=> wdog_window_period_o == $past(fuse1_ff[FUSE1_WIN_LSB +: 4]))
    else $error("watchdog window period not loaded from fuse during reset");
  a_boot_vector: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
    state_ff == NFC_HOLD |=> boot_from_loader_o == !$past(fuse2_ff[FUSE2_BOOT]))
    else $error("boot vector select not taken over during reset");
  a_pin_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    !ext_reset_n_i && fuse4_act_ff[FUSE4_RSTDIS] |=> internal_reset_o && state_ff == NFC_HOLD)
    else $error("low reset pin did not hold the internal reset");
  a_pin_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    !fuse4_act_ff[FUSE4_RSTDIS] && state_ff == NFC_RUN |=> !internal_reset_o)
    else $error("reset pin acted although its disable fuse is programmed");
  a_delay_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RQ18
    state_ff == NFC_DELAY && su_cnt_ff < su_target |=> internal_reset_o)
    else $error("internal reset released before the start-up delay ran out");

  c_flash_op: cover property (@(posedge clk_i) disable iff (rst_i)
    op_start_i && op_is_flash_i ##[1:20] op_done_i);
  c_ee_int: cover property (@(posedge clk_i) disable iff (rst_i)
    nvm_busy_ff ##1 !nvm_busy_ff ##1 ee_ready_int_o != LVL_OFF);
  c_long_delay: cover property (@(posedge clk_i) disable iff (rst_i)
    state_ff == NFC_DELAY && su_cnt_ff == SU_CNT_64);
  c_pin_reset: cover property (@(posedge clk_i) disable iff (rst_i)
    ext_rst_req ##1 state_ff == NFC_HOLD);

endmodule : nfc_top

// ### dv/tb.sv
// Self-checking testbench for the NVM status and fuse configuration block.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module tb;
  import nfc_pkg::*;
  logic clk_i, rst_i, por_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic wb_ack_o, op_start_i, op_is_flash_i, op_done_i, ee_byte_load_i, flash_byte_load_i;
  logic ee_buf_clear_i, flash_buf_clear_i, ext_reset_n_i, ulp_tick_i;
  logic [7:0] lock_bits_i;
  logic [1:0] spm_ready_int_o, ee_ready_int_o, brownout_sleep_mode_o;
  logic app_flash_block_o, boot_from_loader_o, osc_on_xtal_pins_o, wdog_config_lock_o;
  logic internal_reset_o;
  logic [3:0] wdog_window_period_o, wdog_timeout_o;
  logic [15:0] reset_vector_o;
  int n_mismatch = 0;
  int n_compared = 0;
  int nt;
  logic [7:0] adrs [7] = '{8'h44, 8'h48, 8'h50, 8'h10, 8'h1C, 8'h34, 8'h7C};
  logic [7:0] exps [7] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hA5, 8'h00, 8'h00};

  nfc_top nfc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_start_i(op_start_i),
    .op_is_flash_i(op_is_flash_i), .op_done_i(op_done_i), .ee_byte_load_i(ee_byte_load_i),
    .flash_byte_load_i(flash_byte_load_i), .ee_buf_clear_i(ee_buf_clear_i),
    .flash_buf_clear_i(flash_buf_clear_i), .lock_bits_i(lock_bits_i),
    .ext_reset_n_i(ext_reset_n_i), .ulp_tick_i(ulp_tick_i), .spm_ready_int_o(spm_ready_int_o),
    .ee_ready_int_o(ee_ready_int_o), .app_flash_block_o(app_flash_block_o),
    .wdog_window_period_o(wdog_window_period_o), .wdog_timeout_o(wdog_timeout_o),
    .boot_from_loader_o(boot_from_loader_o), .reset_vector_o(reset_vector_o),
    .osc_on_xtal_pins_o(osc_on_xtal_pins_o), .brownout_sleep_mode_o(brownout_sleep_mode_o),
    .wdog_config_lock_o(wdog_config_lock_o), .internal_reset_o(internal_reset_o));

  // Free-running 50 MHz system clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // One classic Wishbone cycle; the request is held until ack is sampled high.
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      final_report();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_cycle

  // Reads a register and compares the whole word.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    wb_cycle(1'b0, a, 8'h00);
    `CHK("read data", {24'h000000, e}, rd)
  endtask : rd_chk

  // System reset for two cycles, optionally with the fuse power-on load.
  task automatic do_reset(input logic por);
    @(posedge clk_i);
    rst_i <= 1'b1;
    por_i <= por;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
  endtask : do_reset

  // Gives slow oscillator ticks until the internal reset lets go, bounded.
  task automatic count_ticks(output int n);
    n = 0;
    repeat (3) @(posedge clk_i);
    while (internal_reset_o === 1'b1 && n < 100) begin
      @(posedge clk_i);
      ulp_tick_i <= 1'b1;
      @(posedge clk_i);
      ulp_tick_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      n++;
    end
  endtask : count_ticks

  // Drives a one-cycle pulse on the operation, buffer load and EEPROM buffer clear strobes.
  task automatic strobe(input logic [4:0] s, input logic fl);
    @(posedge clk_i);
    {op_start_i, op_done_i, ee_byte_load_i, flash_byte_load_i} <= s[4:1];
    ee_buf_clear_i <= s[0];
    op_is_flash_i <= fl;
    @(posedge clk_i);
    {op_start_i, op_done_i, ee_byte_load_i, flash_byte_load_i, ee_buf_clear_i} <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask : strobe

  // Hang guard.
  initial begin
    #1000000;
    n_mismatch++;
    final_report();
  end

  // Main sequence.
  initial begin
    {rst_i, por_i, wb_cyc_i, wb_stb_i, wb_we_i, op_start_i, op_is_flash_i} = 7'h00;
    {op_done_i, ee_byte_load_i, flash_byte_load_i, ee_buf_clear_i, ulp_tick_i} = 5'h00;
    flash_buf_clear_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    lock_bits_i = 8'hA5;
    ext_reset_n_i = 1'b1;
    do_reset(1'b1);
    repeat (4) @(posedge clk_i);
    `CHK("int reset code 11", 1'b0, internal_reset_o)
    for (int k = 0; k < 7; k++) rd_chk(adrs[k], exps[k]);
    wb_cycle(1'b1, 8'h1C, 8'h00);
    wb_cycle(1'b1, 8'h10, 8'hC3);
    rd_chk(8'h1C, 8'hA5);
    rd_chk(8'h10, 8'h00);
    `CHK("boot", 1'b0, boot_from_loader_o)
    `CHK("vector", 16'h0000, reset_vector_o)
    `CHK("osc", 1'b1, osc_on_xtal_pins_o)
    `CHK("bod", 2'h3, brownout_sleep_mode_o)
    `CHK("wdog_config_lock", 1'b0, wdog_config_lock_o)
    for (int l = 0; l < 4; l++) begin
      strobe(5'h10, 1'b0);
      wb_cycle(1'b1, 8'h34, {4'h0, l[1:0], l[1:0]});
      rd_chk(8'h34, {4'h0, l[1:0], l[1:0]});
      strobe(5'h08, 1'b0);
      `CHK("spm int", l[1:0], spm_ready_int_o)
      `CHK("ee int", l[1:0], ee_ready_int_o)
      wb_cycle(1'b1, 8'h34, 8'h00);
    end
    strobe(5'h10, 1'b1);
    wb_cycle(1'b1, 8'h34, 8'h09);
    repeat (2) @(posedge clk_i);
    `CHK("block", 1'b1, app_flash_block_o)
    `CHK("busy ints", 4'h0, {spm_ready_int_o, ee_ready_int_o})
    rd_chk(8'h10, 8'hC0);
    strobe(5'h08, 1'b0);
    `CHK("unblock", 1'b0, app_flash_block_o)
    `CHK("ready ints", 4'h9, {spm_ready_int_o, ee_ready_int_o})
    wb_cycle(1'b1, 8'h34, 8'h00);
    strobe(5'h10, 1'b0);
    rd_chk(8'h10, 8'h80);
    strobe(5'h08, 1'b0);
    strobe(5'h06, 1'b0);
    rd_chk(8'h10, 8'h03);
    strobe(5'h01, 1'b0);
    rd_chk(8'h10, 8'h01);
    @(posedge clk_i);
    flash_buf_clear_i <= 1'b1;
    @(posedge clk_i);
    flash_buf_clear_i <= 1'b0;
    rd_chk(8'h10, 8'h00);
    wb_cycle(1'b1, 8'h44, 8'h5A);
    wb_cycle(1'b1, 8'h48, 8'h9D);
    wb_cycle(1'b1, 8'h50, 8'hE5);
    rd_chk(8'h50, 8'hFF);
    do_reset(1'b0);
    `CHK("window", 4'h5, wdog_window_period_o)
    `CHK("timeout", 4'hA, wdog_timeout_o)
    `CHK("boot", 1'b1, boot_from_loader_o)
    `CHK("vector", 16'h8000, reset_vector_o)
    `CHK("osc", 1'b0, osc_on_xtal_pins_o)
    `CHK("bod", 2'h1, brownout_sleep_mode_o)
    `CHK("wdog_config_lock", 1'b1, wdog_config_lock_o)
    count_ticks(nt);
    `CHK("ticks code 01", 4, nt)
    rd_chk(8'h50, 8'hE5);
    @(posedge clk_i);
    ext_reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK("pin ignored", 1'b0, internal_reset_o)
    ext_reset_n_i <= 1'b1;
    wb_cycle(1'b1, 8'h50, 8'hF3);
    do_reset(1'b0);
    count_ticks(nt);
    `CHK("ticks code 00", 64, nt)
    @(posedge clk_i);
    ext_reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("pin reset", 1'b1, internal_reset_o)
    ext_reset_n_i <= 1'b1;
    count_ticks(nt);
    `CHK("ticks after pin", 64, nt)
    final_report();
  end
endmodule : tb
